/* File: rtl/clgb_consts.svh */
// Purpose: Constants of the configurable logic gate block
// Assumes: Included by the package and the design modules
// Notes: Positions are receiver indices
`ifndef CLGB_CONSTS_SVH
`define CLGB_CONSTS_SVH

`define CLGB_NUM_IN 8
`define CLGB_FUNC_W 4
`define CLGB_ERRH_W 2
`define CLGB_LATCH_SRC_IDX 0
`define CLGB_LATCH_HOLD_IDX 1
`define CLGB_FF_SET_IDX 0
`define CLGB_FF_CLR_IDX 1
`define CLGB_OUT_VAL_RST 1'b0
`define CLGB_OUT_ERR_RST 1'b0
`define CLGB_HELD_RST 1'b0
`define CLGB_HOLD_PREV_RST 1'b0
`define CLGB_FF_Q_RST 1'b0

`endif

/* File: rtl/clgb_pkg.sv */
// Purpose: Types of the configurable logic gate block
// Assumes: Constants header on the include path
// Notes: Function codes 9 to 15 are illegal and act as off
`include "clgb_consts.svh"

package clgb_pkg;

    typedef enum logic [`CLGB_FUNC_W-1:0] {
        CLGB_OFF = 4'h0,
        CLGB_AND = 4'h1,
        CLGB_NAND = 4'h2,
        CLGB_ALL_EQUAL_OP = 4'h3,
        CLGB_NOT_ALL_EQUAL_OP = 4'h4,
        CLGB_OR = 4'h5,
        CLGB_NOR = 4'h6,
        CLGB_LATCH = 4'h7,
        CLGB_FLIP_FLOP = 4'h8
    } clgb_func_t;

    typedef enum logic [`CLGB_ERRH_W-1:0] {
        CLGB_TRUE_GOOD = 2'h0,
        CLGB_TRUE_BAD = 2'h1,
        CLGB_FALSE_GOOD = 2'h2,
        CLGB_FALSE_BAD = 2'h3
    } clgb_errh_t;

    typedef struct packed {
        logic out_val;
        logic out_err;
        logic held;
        logic hold_prev;
        logic ff_q;
    } clgb_state_t;

endpackage

/* File: rtl/clgb_eval.sv */
// Purpose: Combinational evaluation of the eight-input gate functions
// Assumes: Inputs come from logic on the same clock
// Notes: Unconnected receivers are masked out before any reduction
`timescale 1ns/1ps
`include "clgb_consts.svh"

module clgb_eval (
    input wire logic [`CLGB_NUM_IN-1:0] in_val,
    input wire logic [`CLGB_NUM_IN-1:0] in_conn,
    input wire logic [`CLGB_NUM_IN-1:0] in_err,
    input wire clgb_pkg::clgb_func_t func_sel,
    output logic gate_res,
    output logic gate_undet
);

    logic any_true;
    logic all_true;
    logic all_false;

    assign any_true = |(in_val & in_conn);
    assign all_true = &(in_val | ~in_conn);
    assign all_false = ~any_true;

    // No connected receiver, or a connected one in error
    assign gate_undet = (in_conn == 8'h00) || (|(in_err & in_conn));

    always_comb begin
        unique case (func_sel)
            clgb_pkg::CLGB_AND: gate_res = all_true;
            clgb_pkg::CLGB_NAND: gate_res = ~all_true;
            clgb_pkg::CLGB_ALL_EQUAL_OP: gate_res = all_true | all_false;
            clgb_pkg::CLGB_NOT_ALL_EQUAL_OP: gate_res = ~(all_true | all_false);
            clgb_pkg::CLGB_OR: gate_res = any_true;
            clgb_pkg::CLGB_NOR: gate_res = all_false;
            default: gate_res = 1'b0;
        endcase
    end

endmodule

/* File: rtl/clgb_top.sv */
// Purpose: Configurable logic gate block with registered value and error
// Assumes: Receivers driven by logic on clk; one clock, async low reset
// Notes: Latch and flip-flop use receivers 0 and 1
//
// Overview of operation
// - Off function drives output false
// - Values are two-level: false or true
// - And: true only if all true
// - Nand: true if any input false
// - All-equal: true when inputs agree
// - Not-all-equal: true when any two differ
// - Or: true if any input true
// - Nor: true only if all false
// - Latch follows source, holds on hold rise
// - Flip-flop set forces true, clear false; clear wins when both are raised
// - Unconnected inputs excluded from evaluation
// - Undetermined result uses error-handling setting
`timescale 1ns/1ps
`include "clgb_consts.svh"

module clgb_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`CLGB_NUM_IN-1:0] in_val,
    input wire logic [`CLGB_NUM_IN-1:0] in_conn,
    input wire logic [`CLGB_NUM_IN-1:0] in_err,
    input wire clgb_pkg::clgb_func_t func_sel,
    input wire clgb_pkg::clgb_errh_t err_sel,
    output logic out_val,
    output logic out_err
);

    clgb_pkg::clgb_state_t st_r;
    clgb_pkg::clgb_state_t st_nxt;
    logic gate_res;
    logic gate_undet;
    logic src_in;
    logic hold_in;
    logic set_in;
    logic clr_in;
    logic latch_undet;
    logic ff_undet;
    logic errh_val;
    logic errh_err;

    ////////////////////////////////////////////////////////////////////////
    // Gate evaluation

    clgb_eval u_eval (
        .in_val(in_val),
        .in_conn(in_conn),
        .in_err(in_err),
        .func_sel(func_sel),
        .gate_res(gate_res),
        .gate_undet(gate_undet)
    );

    ////////////////////////////////////////////////////////////////////////
    // Dedicated receivers; unconnected ones read as false

    assign src_in = in_val[`CLGB_LATCH_SRC_IDX] & in_conn[`CLGB_LATCH_SRC_IDX];
    assign hold_in = in_val[`CLGB_LATCH_HOLD_IDX] & in_conn[`CLGB_LATCH_HOLD_IDX];
    assign set_in = in_val[`CLGB_FF_SET_IDX] & in_conn[`CLGB_FF_SET_IDX];
    assign clr_in = in_val[`CLGB_FF_CLR_IDX] & in_conn[`CLGB_FF_CLR_IDX];

    // Missing source or an erroneous control leaves the result unknown
    assign latch_undet = ~in_conn[`CLGB_LATCH_SRC_IDX]
        | (in_err[`CLGB_LATCH_SRC_IDX] & in_conn[`CLGB_LATCH_SRC_IDX])
        | (in_err[`CLGB_LATCH_HOLD_IDX] & in_conn[`CLGB_LATCH_HOLD_IDX]);
    assign ff_undet = (in_err[`CLGB_FF_SET_IDX] & in_conn[`CLGB_FF_SET_IDX])
        | (in_err[`CLGB_FF_CLR_IDX] & in_conn[`CLGB_FF_CLR_IDX]);

    assign errh_val = (err_sel == clgb_pkg::CLGB_TRUE_GOOD) || (err_sel == clgb_pkg::CLGB_TRUE_BAD);
    assign errh_err = (err_sel == clgb_pkg::CLGB_TRUE_BAD) || (err_sel == clgb_pkg::CLGB_FALSE_BAD);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.hold_prev = hold_in;
            unique case (func_sel)
                clgb_pkg::CLGB_AND, clgb_pkg::CLGB_NAND, clgb_pkg::CLGB_ALL_EQUAL_OP,
                clgb_pkg::CLGB_NOT_ALL_EQUAL_OP, clgb_pkg::CLGB_OR, clgb_pkg::CLGB_NOR: begin
                    st_nxt.out_val = gate_undet ? errh_val : gate_res;
                    st_nxt.out_err = gate_undet ? errh_err : 1'b0;
                end
                clgb_pkg::CLGB_LATCH: begin
                    if (latch_undet) begin
                        st_nxt.out_val = errh_val;
                        st_nxt.out_err = errh_err;
                    end else begin
                        if (!hold_in || !st_r.hold_prev) begin
                            st_nxt.held = src_in;
                        end
                        st_nxt.out_val = (!hold_in || !st_r.hold_prev) ? src_in : st_r.held;
                        st_nxt.out_err = 1'b0;
                    end
                end
                clgb_pkg::CLGB_FLIP_FLOP: begin
                    if (ff_undet) begin
                        st_nxt.out_val = errh_val;
                        st_nxt.out_err = errh_err;
                    end else begin
                        if (clr_in) begin
                            st_nxt.ff_q = 1'b0;
                        end else if (set_in) begin
                            st_nxt.ff_q = 1'b1;
                        end
                        st_nxt.out_val = clr_in ? 1'b0 : (set_in ? 1'b1 : st_r.ff_q);
                        st_nxt.out_err = 1'b0;
                    end
                end
                default: begin
                    st_nxt.out_val = 1'b0;
                    st_nxt.out_err = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.out_val <= `CLGB_OUT_VAL_RST;
            st_r.out_err <= `CLGB_OUT_ERR_RST;
            st_r.held <= `CLGB_HELD_RST;
            st_r.hold_prev <= `CLGB_HOLD_PREV_RST;
            st_r.ff_q <= `CLGB_FF_Q_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_val = st_r.out_val;
    assign out_err = st_r.out_err;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    off_false_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_OFF |=> !out_val && !out_err)
        else $error("off function did not drive false");

    and_mask_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_AND && in_conn != 8'h00
        && (in_err & in_conn) == 8'h00 |=> out_val == $past(&(in_val | ~in_conn)) && !out_err)
        else $error("and result wrong");

    nand_mask_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_NAND && in_conn != 8'h00
        && (in_err & in_conn) == 8'h00 |=> out_val == !$past(&(in_val | ~in_conn)))
        else $error("nand result wrong");

    equal_mask_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_ALL_EQUAL_OP && in_conn != 8'h00
        && (in_err & in_conn) == 8'h00 |=> out_val == $past(((in_val & in_conn) == 8'h00)
        || ((in_val & in_conn) == in_conn)))
        else $error("all-equal result wrong");

    nequal_mask_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_NOT_ALL_EQUAL_OP
        && in_conn != 8'h00 && (in_err & in_conn) == 8'h00 |=> out_val == $past(((in_val & in_conn) != 8'h00)
        && ((in_val & in_conn) != in_conn)))
        else $error("not-all-equal result wrong");

    or_mask_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_OR && in_conn != 8'h00
        && (in_err & in_conn) == 8'h00 |=> out_val == $past(|(in_val & in_conn)))
        else $error("or result wrong");

    nor_mask_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_NOR && in_conn != 8'h00
        && (in_err & in_conn) == 8'h00 |=> out_val == !$past(|(in_val & in_conn)))
        else $error("nor result wrong");

    latch_hold_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_LATCH && !latch_undet && hold_in
        && !st_r.hold_prev ##1 (clk_en && func_sel == clgb_pkg::CLGB_LATCH && !latch_undet && hold_in)
        |=> out_val == $past(src_in, 2))
        else $error("latch did not hold captured value");

    ff_clear_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_FLIP_FLOP && !ff_undet && clr_in
        |=> !out_val && !out_err)
        else $error("clear did not win over set");

    ff_keep_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_FLIP_FLOP && !ff_undet && clr_in
        ##1 (clk_en && func_sel == clgb_pkg::CLGB_FLIP_FLOP && !ff_undet && !clr_in && !set_in)
        |=> !out_val)
        else $error("flip-flop lost cleared state");

    ff_set_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_FLIP_FLOP && !ff_undet && set_in
        && !clr_in |=> out_val && !out_err)
        else $error("set did not force true");

    undet_map_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_OR && in_conn == 8'h00
        |=> out_val == $past(errh_val) && out_err == $past(errh_err))
        else $error("error handling value wrong");

    latch_undet_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_LATCH && latch_undet
        |=> out_val == $past(errh_val) && out_err == $past(errh_err))
        else $error("latch error handling wrong");

    ff_undet_a: assert property (clk_en && func_sel == clgb_pkg::CLGB_FLIP_FLOP && ff_undet
        |=> out_val == $past(errh_val) && out_err == $past(errh_err))
        else $error("flip-flop error handling wrong");

    freeze_a: assert property (!clk_en |=> $stable(out_val) && $stable(out_err))
        else $error("state changed with enable low");

    latch_cv: cover property (clk_en && func_sel == clgb_pkg::CLGB_LATCH && hold_in && !st_r.hold_prev);
    ff_both_cv: cover property (clk_en && func_sel == clgb_pkg::CLGB_FLIP_FLOP && set_in && clr_in);
    undet_cv: cover property (clk_en && gate_undet && func_sel == clgb_pkg::CLGB_AND ##1 out_err);
    neq_cv: cover property (clk_en && func_sel == clgb_pkg::CLGB_NOT_ALL_EQUAL_OP ##1 out_val);

endmodule

/* File: tb/clgb_src.sv */
// Purpose: Upstream function blocks feeding the eight receivers
// Assumes: Called by the bench just after a rising clock edge
// Notes: Unconnected receivers carry junk and a raised error flag
`timescale 1ns/1ps

module clgb_src (
    output logic [7:0] in_val,
    output logic [7:0] in_conn,
    output logic [7:0] in_err
);
    initial begin
        in_val = 8'h00;
        in_conn = 8'h00;
        in_err = 8'h00;
    end

    // Junk toggles on unconnected receivers so a leak shows
    task automatic put(input logic [7:0] v, input logic [7:0] c, input logic [7:0] e);
        in_val = (v & c) | (~in_val & ~c);
        in_conn = c;
        in_err = e | ~c;
    endtask
endmodule

/* File: tb/configurable_logic_gate_block_tb_top.sv */
// Purpose: Self-checking bench for the logic gate block
// Assumes: One result per enabled edge, seen just after it
// Notes: Inputs change 1 ns after each rising edge
`timescale 1ns/1ps

module configurable_logic_gate_block_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] in_val;
    logic [7:0] in_conn;
    logic [7:0] in_err;
    clgb_pkg::clgb_func_t func_sel = clgb_pkg::CLGB_OFF;
    clgb_pkg::clgb_errh_t err_sel = clgb_pkg::CLGB_TRUE_GOOD;
    logic out_val;
    logic out_err;
    int miscompares = 0;
    int cmp_count = 0;

    initial begin
        forever #20 clk = ~clk;
    end

    clgb_src u_src (.in_val(in_val), .in_conn(in_conn), .in_err(in_err));

    clgb_top u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .in_val(in_val), .in_conn(in_conn),
        .in_err(in_err), .func_sel(func_sel), .err_sel(err_sel), .out_val(out_val), .out_err(out_err));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic ev, input logic ee);
        cmp_count++;
        if (out_val !== ev || out_err !== ee) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h/%h exp %h/%h", $time, out_val, out_err, ev, ee);
        end
    endtask

    task automatic app(input int f, input logic [7:0] v, input logic [7:0] c, input logic [7:0] e);
        func_sel = clgb_pkg::clgb_func_t'(f);
        u_src.put(v, c, e);
        @(posedge clk);
        #1;
    endtask

    // Expected gate result over connected receivers only
    function automatic logic gexp(input int f, input logic [7:0] v, input logic [7:0] c);
        logic t;
        logic z;
        t = &(v | ~c);
        z = ~|(v & c);
        case (f)
            1: return t;
            2: return ~t;
            3: return t | z;
            4: return ~(t | z);
            5: return ~z;
            6: return z;
            default: return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    task automatic t_gates();
        logic [7:0] pv [5] = '{8'h07, 8'h03, 8'h00, 8'h81, 8'h80};
        logic [7:0] pc [5] = '{8'h07, 8'h07, 8'h81, 8'h81, 8'h81};
        int fc;
        for (int f = 0; f < 8; f++) begin
            fc = (f == 7) ? 9 : f;
            for (int i = 0; i < 5; i++) begin
                app(fc, pv[i], pc[i], 8'h00);
                chk(gexp(fc, pv[i], pc[i]), 1'b0);
            end
        end
    endtask

    task automatic t_undet();
        for (int s = 0; s < 4; s++) begin
            err_sel = clgb_pkg::clgb_errh_t'(s);
            app(1, 8'hff, 8'h00, 8'h00);
            chk(~s[1], s[0]);
            app(5, 8'hff, 8'h0f, 8'h04);
            chk(~s[1], s[0]);
            app(7, 8'h00, 8'h02, 8'h00);
            chk(~s[1], s[0]);
            app(8, 8'h01, 8'h03, 8'h01);
            chk(~s[1], s[0]);
            app(0, 8'hff, 8'hff, 8'hff);
            chk(1'b0, 1'b0);
        end
        err_sel = clgb_pkg::CLGB_TRUE_GOOD;
    endtask

    // Receiver 0 is source or set, receiver 1 hold or clear
    task automatic t_seq(input int f, input logic [47:0] vs, input logic [5:0] es);
        for (int i = 5; i >= 0; i--) begin
            app(f, vs[8*i +: 8], 8'h03, 8'h00);
            chk(es[i], 1'b0);
        end
    endtask

    task automatic t_freeze();
        app(8, 8'h01, 8'h03, 8'h00);
        chk(1'b1, 1'b0);
        clk_en = 1'b0;
        app(8, 8'h02, 8'h03, 8'h00);
        chk(1'b1, 1'b0);
        clk_en = 1'b1;
        rst_n = 1'b0;
        #1;
        chk(1'b0, 1'b0);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        app(8, 8'h00, 8'h03, 8'h00);
        chk(1'b0, 1'b0);
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(1'b0, 1'b0);
        t_gates();
        t_undet();
        t_seq(7, 48'h01_02_03_01_03_02, 6'b100111);
        t_seq(8, 48'h01_00_03_00_01_02, 6'b110010);
        t_freeze();
        test_done();
    end
endmodule
